// >>> ssr_pkg.sv
package ssr_pkg;

	// Clock rate and derived timing.
	localparam int unsigned CLK_HZ            = 125_000_000;
	localparam int unsigned CLK_PERIOD_PS     = 8_000;

	// Reset stretch after every cause clears, least time.
	localparam int unsigned STRETCH_MS        = 140;
	localparam longint unsigned STRETCH_CYC_L = (64'(STRETCH_MS) * 64'(CLK_HZ) + 64'd999) / 64'd1000;
	localparam int unsigned STRETCH_CYC       = int'(STRETCH_CYC_L);

	// Manual reset debounce: a low that stands this long is taken, shorter lows are bounce.
	localparam int unsigned MR_DEBOUNCE_NS    = 2_000;
	localparam int unsigned MR_DEBOUNCE_CYC   = (MR_DEBOUNCE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Comparator glitch filter: excursions shorter than this are ignored.
	localparam int unsigned GLITCH_NS         = 8_400;
	localparam int unsigned GLITCH_CYC        = (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Values after reset.
	localparam logic        RST_ACTIVE_INIT   = 1'b1;
	localparam logic        OV_INIT           = 1'b0;

	typedef struct packed {
		logic undervolt;
		logic overvolt;
		logic manual;
	} ssr_cause_s;

	typedef enum logic [1:0] {
		SSR_HOLD,
		SSR_STRETCH,
		SSR_RUN
	} ssr_state_e;

endpackage

// >>> ssr_filter.sv
`timescale 1ns/1ps
// Two-stage synchroniser followed by a qualification counter.  The output
// only changes once the synchronised input has held the opposite level for
// HOLD_CYC cycles in a row, so shorter pulses are swallowed.
module ssr_filter #(
	parameter int unsigned HOLD_CYC = 16,
	parameter logic        INIT     = 1'b0
) (
	input  wire logic i_mclk, // Clock.
	input  wire logic i_rst,  // Asynchronous reset, active high.
	input  wire logic i_raw,  // Asynchronous input.
	output logic      o_flt   // Filtered level.
);
	localparam int unsigned CW = $clog2(HOLD_CYC + 1);

	logic          meta_q;
	logic          sync_q;
	logic [CW-1:0] cnt_q;

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= INIT;
			sync_q <= INIT;
		end else begin
			meta_q <= i_raw;
			sync_q <= meta_q;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= '0;
			o_flt <= INIT;
		end else if (sync_q == o_flt) begin
			cnt_q <= '0;
		end else if (cnt_q >= CW'(HOLD_CYC - 1)) begin
			cnt_q <= '0;
			o_flt <= sync_q;
		end else begin
			cnt_q <= cnt_q + CW'(1);
		end
	end

endmodule

// >>> ssr_top.sv
`timescale 1ns/1ps
// What this block does
// RULE_01: Reset stays asserted while manual reset is active or the supply is below the lower or above the upper trip level.
// RULE_02: Once all causes clear, reset stays asserted for at least 140 ms before release.
// RULE_03: At power-on a reset pulse of at least 140 ms is produced before the first release.
// RULE_04: Output polarity is a build parameter, active high or active low, with identical timing.
// RULE_05: A recognised manual reset asserts reset at once and restarts any timing in progress.
// RULE_06: The manual reset input is debounced so switch bounce gives no repeated reset cycles.
// RULE_07: Overvoltage asserts both the overvoltage flag and reset immediately and unconditionally.
// RULE_08: The overvoltage flag is active low and open drain: it only pulls low or floats.
// RULE_09: Very brief excursions beyond either trip level are ignored.
// RULE_10: Whoever drives manual reset holds it low for at least 2.5 us to be recognised.
// RULE_11: The stretch is a counter that restarts while any cause is active and releases after a full interval.
module ssr_top #(
	parameter int unsigned STRETCH_CYC  = ssr_pkg::STRETCH_CYC,
	parameter bit          RST_ACT_HIGH = 1'b0
) (
	input  wire logic i_mclk,                  // 125 MHz clock.
	input  wire logic i_rst,                   // Power-on reset, async, active high.
	input  wire logic i_manual_reset_n,        // Manual reset pin, active low.
	input  wire logic i_below_lower_trip_level, // Undervoltage comparator, async.
	input  wire logic i_above_upper_trip_level, // Overvoltage comparator, async.
	output logic      o_reset,                 // Processor reset, polarity per RST_ACT_HIGH.
	output logic      o_overvoltage_flag_n_o,  // Overvoltage flag pin output value, always low.
	output logic      o_overvoltage_flag_n_oe  // Overvoltage flag output enable, low while pulling.
);
	localparam int unsigned SW = $clog2(STRETCH_CYC + 1);

	ssr_pkg::ssr_cause_s cause;
	ssr_pkg::ssr_state_e state_q;
	ssr_pkg::ssr_state_e state_d;
	logic [SW-1:0]       cnt_q;
	logic                mr_n_flt;
	logic                uv_flt;
	logic                ov_flt;
	logic                rst_act_d;

	// Switch bounce shorter than the debounce time never reaches the sequencer.
	ssr_filter #(
		.HOLD_CYC (ssr_pkg::MR_DEBOUNCE_CYC),
		.INIT     (1'b1)
	) u_mr_filt (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_raw  (i_manual_reset_n),
		.o_flt  (mr_n_flt)
	); // RULE_06 RULE_10

	ssr_filter #(
		.HOLD_CYC (ssr_pkg::GLITCH_CYC),
		.INIT     (1'b0)
	) u_uv_filt (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_raw  (i_below_lower_trip_level),
		.o_flt  (uv_flt)
	); // RULE_09

	ssr_filter #(
		.HOLD_CYC (ssr_pkg::GLITCH_CYC),
		.INIT     (1'b0)
	) u_ov_filt (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_raw  (i_above_upper_trip_level),
		.o_flt  (ov_flt)
	); // RULE_09

	// One driver for the whole cause word keeps each bit of it single-sourced.
	assign cause = '{undervolt: uv_flt, overvolt: ov_flt, manual: ~mr_n_flt};

	// Any active cause forces the hold state, whatever the stretch was doing.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ssr_pkg::SSR_HOLD: begin
				if (!(|cause)) begin
					state_d = ssr_pkg::SSR_STRETCH;
				end
			end
			ssr_pkg::SSR_STRETCH: begin
				if (|cause) begin
					state_d = ssr_pkg::SSR_HOLD; // RULE_05 RULE_07
				end else if (cnt_q >= SW'(STRETCH_CYC - 1)) begin
					state_d = ssr_pkg::SSR_RUN; // RULE_02
				end
			end
			ssr_pkg::SSR_RUN: begin
				if (|cause) begin
					state_d = ssr_pkg::SSR_HOLD; // RULE_01
				end
			end
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= ssr_pkg::SSR_HOLD; // RULE_03
		end else begin
			state_q <= state_d;
		end
	end

	// Stretch counter restarts on any cause; it is a full count, never resumed.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= '0;
		end else if (state_q != ssr_pkg::SSR_STRETCH || (|cause)) begin
			cnt_q <= '0; // RULE_11
		end else begin
			cnt_q <= cnt_q + SW'(1); // RULE_11
		end
	end

	// Reset is taken from the next state so a cause shows on the pin one edge after filtering.
	assign rst_act_d = (state_d != ssr_pkg::SSR_RUN); // RULE_01

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_reset <= RST_ACT_HIGH ? ssr_pkg::RST_ACTIVE_INIT : ~ssr_pkg::RST_ACTIVE_INIT;
		end else begin
			o_reset <= RST_ACT_HIGH ? rst_act_d : ~rst_act_d; // RULE_04
		end
	end

	// Open drain: the data bit is fixed low and only the enable moves, so the
	// pin can never be driven high and stays safe to wire with other drains.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_overvoltage_flag_n_o  <= 1'b0;
			o_overvoltage_flag_n_oe <= ~ssr_pkg::OV_INIT;
		end else begin
			o_overvoltage_flag_n_o  <= 1'b0; // RULE_08
			o_overvoltage_flag_n_oe <= ~cause.overvolt; // RULE_07
		end
	end

	// Assertions.
	logic rst_act;
	assign rst_act = RST_ACT_HIGH ? o_reset : ~o_reset;

	property p_cause_holds_reset;
		@(posedge i_mclk) disable iff (i_rst)
		(|cause) |=> rst_act;
	endproperty
	a_cause_holds_reset: assert property (p_cause_holds_reset) else $error("reset released while a cause is active"); // RULE_01

	property p_release_after_stretch;
		@(posedge i_mclk) disable iff (i_rst)
		(rst_act && !(|cause) && state_q == ssr_pkg::SSR_STRETCH && cnt_q == '0) ##1 (!(|cause))[*8] |-> rst_act;
	endproperty
	a_release_after_stretch: assert property (p_release_after_stretch) else $error("reset released too early"); // RULE_02

	property p_release_count;
		@(posedge i_mclk) disable iff (i_rst)
		$fell(rst_act) |-> $past(cnt_q) == SW'(STRETCH_CYC - 1);
	endproperty
	a_release_count: assert property (p_release_count) else $error("reset released without a full stretch"); // RULE_11

	property p_ov_flag;
		@(posedge i_mclk) disable iff (i_rst)
		cause.overvolt |=> (!o_overvoltage_flag_n_oe && rst_act);
	endproperty
	a_ov_flag: assert property (p_ov_flag) else $error("overvoltage not flagged"); // RULE_07

	property p_ov_drain;
		@(posedge i_mclk) disable iff (i_rst)
		!o_overvoltage_flag_n_o && (o_overvoltage_flag_n_oe || $past(cause.overvolt));
	endproperty
	a_ov_drain: assert property (p_ov_drain) else $error("flag pin driven high"); // RULE_08

	property p_manual_restart;
		@(posedge i_mclk) disable iff (i_rst)
		(cause.manual && state_q == ssr_pkg::SSR_STRETCH) |=> (state_q == ssr_pkg::SSR_HOLD && cnt_q == '0);
	endproperty
	a_manual_restart: assert property (p_manual_restart) else $error("manual reset did not restart timing"); // RULE_05

	property p_manual_debounce;
		@(posedge i_mclk) disable iff (i_rst)
		$fell(mr_n_flt) |-> $past(u_mr_filt.sync_q, 2) == 1'b0;
	endproperty
	a_manual_debounce: assert property (p_manual_debounce) else $error("manual reset taken without a held low"); // RULE_06

	property p_glitch;
		@(posedge i_mclk) disable iff (i_rst)
		$rose(cause.undervolt) |-> $past(u_uv_filt.sync_q, 2);
	endproperty
	a_glitch: assert property (p_glitch) else $error("undervoltage glitch not filtered"); // RULE_09

	property p_polarity;
		@(posedge i_mclk) disable iff (i_rst)
		(state_q == ssr_pkg::SSR_HOLD) |-> (o_reset == RST_ACT_HIGH);
	endproperty
	a_polarity: assert property (p_polarity) else $error("reset polarity wrong"); // RULE_04

	c_release:  cover property (@(posedge i_mclk) disable iff (i_rst) $fell(rst_act)); // RULE_03
	c_manual:   cover property (@(posedge i_mclk) disable iff (i_rst) $rose(cause.manual));
	c_overvolt: cover property (@(posedge i_mclk) disable iff (i_rst) $rose(cause.overvolt));

endmodule

// >>> ssr_host_model.sv
`timescale 1ns/1ps
// Processor reset input and crowbar gate; the flag wire has a pull-up, so it floats high.
module ssr_host_model #(
	parameter bit ACT_HIGH = 1'b0
) (
	input  wire logic i_reset,   // Reset pin level.
	input  wire logic i_flag_o,  // Flag drive value.
	input  wire logic i_flag_oe, // Flag enable, low drives.
	output logic      o_in_rst,  // Processor held in reset.
	output logic      o_crowbar  // Crowbar gate fired.
);
	assign o_in_rst  = ACT_HIGH ? i_reset : ~i_reset;
	assign o_crowbar = ~(i_flag_oe ? 1'b1 : i_flag_o);
endmodule

// >>> test_supply_supervisor_reset.sv
`timescale 1ns/1ps
module test_supply_supervisor_reset;
	localparam int SC = 600;
	localparam int DB = ssr_pkg::MR_DEBOUNCE_CYC;
	localparam int GF = ssr_pkg::GLITCH_CYC;
	logic clk, rst, mr_n, uv, ov, rl, rh, fo, foe, fo_h, foe_h, in_rst, in_rst_h, crow, crow_h;
	int   fail_count = 0;
	int   cmp_count  = 0;
	ssr_top #(.STRETCH_CYC(SC), .RST_ACT_HIGH(1'b0)) u_dut (.i_mclk(clk), .i_rst(rst),
		.i_manual_reset_n(mr_n), .i_below_lower_trip_level(uv), .i_above_upper_trip_level(ov),
		.o_reset(rl), .o_overvoltage_flag_n_o(fo), .o_overvoltage_flag_n_oe(foe));
	ssr_top #(.STRETCH_CYC(SC), .RST_ACT_HIGH(1'b1)) u_dut_hi (.i_mclk(clk), .i_rst(rst),
		.i_manual_reset_n(mr_n), .i_below_lower_trip_level(uv), .i_above_upper_trip_level(ov),
		.o_reset(rh), .o_overvoltage_flag_n_o(fo_h), .o_overvoltage_flag_n_oe(foe_h));
	ssr_host_model #(.ACT_HIGH(1'b0)) u_host (.i_reset(rl), .i_flag_o(fo), .i_flag_oe(foe),
		.o_in_rst(in_rst), .o_crowbar(crow));
	ssr_host_model #(.ACT_HIGH(1'b1)) u_host_hi (.i_reset(rh), .i_flag_o(fo_h), .i_flag_oe(foe_h),
		.o_in_rst(in_rst_h), .o_crowbar(crow_h));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic stop_test();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic chk_rst(input logic exp);
		check(in_rst, exp);
		check(in_rst_h, exp);
	endtask
	task automatic chk_crow(input logic exp);
		check(crow, exp);
		check(crow_h, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_rst(input logic exp, input int max, output int n);
		n = 0;
		while (in_rst !== exp && n < max) begin
			@(negedge clk);
			n++;
		end
	endtask
	// The cause has just cleared at the pin; the filter delay adds to the stretch.
	task automatic stretch(input int flt);
		int n;
		chk_rst(1'b1);
		wait_rst(1'b0, flt + SC + 20, n);
		check(n >= flt + SC && n <= flt + SC + 8, 1'b1);
		chk_rst(1'b0);
	endtask
	task automatic t_power();
		int n;
		chk_rst(1'b1);
		chk_crow(1'b0);
		rst = 1'b0;
		wait_rst(1'b0, SC + 10, n);
		check(n >= SC, 1'b1);
	endtask
	task automatic t_pulse(input int kind, input int flt);
		int n;
		// A pulse well short of the filter is bounce or a glitch and must leave reset alone.
		for (int k = 0; k < 2; k++) begin
			mr_n = (kind != 0);
			uv   = (kind == 1);
			ov   = (kind == 2);
			cyc(k == 0 ? flt / 2 : 0);
			if (k == 0) begin
				mr_n = 1'b1;
				uv   = 1'b0;
				ov   = 1'b0;
				cyc(20);
				chk_rst(1'b0);
				chk_crow(1'b0);
			end
		end
		wait_rst(1'b1, flt + 10, n);
		check(n >= flt && n <= flt + 8, 1'b1);
		cyc(flt + 60);
		chk_rst(1'b1);
		chk_crow(kind == 2);
		mr_n = 1'b1;
		uv   = 1'b0;
		ov   = 1'b0;
		stretch(flt);
		chk_crow(1'b0);
	endtask
	// The second press lands after the first release is debounced but before its stretch ends.
	task automatic t_restart();
		mr_n = 1'b0;
		cyc(DB + 70);
		mr_n = 1'b1;
		cyc(DB + SC / 2);
		chk_rst(1'b1);
		mr_n = 1'b0;
		cyc(DB + 70);
		mr_n = 1'b1;
		stretch(DB);
	endtask
	initial begin
		rst  = 1'b1;
		mr_n = 1'b1;
		uv   = 1'b0;
		ov   = 1'b0;
		cyc(20);
		t_power();
		t_pulse(0, DB);
		t_pulse(1, GF);
		t_pulse(2, GF);
		t_restart();
		stop_test();
	end
	initial begin
		#160000;
		fail_count++;
		stop_test();
	end
endmodule
